// ===== mmc_regs.svh
/*
 Register offsets, field positions, reset values and timing counts
 for the memory-map control block. Assumes inclusion by bare name.
*/
`ifndef MMC_REGS_SVH
`define MMC_REGS_SVH
`define MMC_OFF_MAP_TEST_0     8'hF8
`define MMC_OFF_MAP_TEST_1     8'hF9
`define MMC_OFF_MAP_TEST_2     8'hFA
`define MMC_OFF_MAP_TEST_3     8'hFB
`define MMC_OFF_MAP_CTRL       8'hFF
`define MMC_BIT_TEST_WINDOW    7
`define MMC_BIT_NARROW_FOLLOW  6
`define MMC_BIT_FOLLOW_HI      5
`define MMC_BIT_FOLLOW_LO      4
`define MMC_BIT_EXT_HI         3
`define MMC_BIT_EXT_LO         2
`define MMC_BIT_UPPER_HALF     1
`define MMC_BIT_FLASH_ENABLE   0
`define MMC_RST_CTRL_EXP       8'h0C
`define MMC_RST_CTRL_SC        8'h0D
`define MMC_RST_FOLLOW_BASE    6'h01
`define MMC_ECLK_DIV           8'h04
`endif

// ===== mmc_pkg.sv
/*
 Types shared by the memory-map control block.
 Assumes the operating mode is supplied by the mode logic.
*/
package mmc_pkg;
    typedef enum logic [2:0] {
        MMC_SPEC_SC   = 3'h0,
        MMC_SPEC_XN   = 3'h1,
        MMC_SPEC_PER  = 3'h2,
        MMC_SPEC_XW   = 3'h3,
        MMC_NORM_SC   = 3'h4,
        MMC_NORM_XN   = 3'h5,
        MMC_NORM_PER  = 3'h6,
        MMC_NORM_XW   = 3'h7
    } mmc_mode_type;
    typedef enum logic [1:0] {
        MMC_ST_IDLE    = 2'h0,
        MMC_ST_STRETCH = 2'h1,
        MMC_ST_DONE    = 2'h2
    } mmc_state_type;
endpackage : mmc_pkg

// ===== mmc_test_reg.sv
/*
 One read-to-clear mapping test register.
 Assumes capture pulses come from the same clock domain.
*/
`timescale 1ns/1ps
module mmc_test_reg
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Capture and clear
    input  wire logic [7:0] setBits,
    input  wire logic       readClr,
    // Value
    output logic      [7:0] value
);
    // Set wins over the read clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            value <= 8'h00;
        else if (readClr)
            value <= setBits; // [RQ14]
        else
            value <= value | setBits;
    end
endmodule : mmc_test_reg

// ===== mmc_map_ctrl.sv
/*
 Memory-map control: write-protected mapping control register,
 flash window decode, follow-space decode, E-clock stretch and four
 read-to-clear test registers.
 Assumes a plain one-cycle register port and a mode input on clk.
*/
// Operation
// RQ1: Normal modes accept only the first control write, special modes any, reads always.
// RQ2: The test-window bit is held zero in normal modes.
// RQ3: Test window clear maps 16K flash at 8000-BFFF, set maps 32K at 8000-FFFF.
// RQ4: The narrow follow-bus option acts only in expanded wide modes.
// RQ5: Narrow bit clear gives a 16-bit follow space, set gives 8-bit over port A.
// RQ6: The follow space sits right after the register block and moves with it.
// RQ7: Follow-space accesses stretch by the two-bit follow stretch field; the code does so only in expanded modes.
// RQ8: External accesses stretch by the external field; none in single-chip or peripheral.
// RQ9: Flash is in the map only while flash enable is one.
// RQ10: Upper-half-only is ignored while flash enable is clear.
// RQ11: Upper-half-only blocks fixed flash at 4000-7FFF; paged window still reaches it.
// RQ12: Special mode with test window and upper-half-only selects all four arrays at once.
// RQ13: Software clears upper-half-only before reading arrays after the overlay.
// RQ14: The four test registers are read-only and clear after each read.
// RQ15: In the test window page-index bits 2 and 1 pick one of four 32K arrays.
// RQ16: A reset-only flag marks that the first control write has happened.
// RQ17: Each stretch cycle adds one whole E period with address held.
`include "mmc_regs.svh"
`timescale 1ns/1ps
module mmc_map_ctrl
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Register port
    input  wire logic [7:0]           regAddr,
    input  wire logic [7:0]           regWrData,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic      [7:0]           regRdData,
    // Mode and mapping inputs
    input  wire mmc_pkg::mmc_mode_type opMode,
    input  wire logic [4:0]           regBase,
    input  wire logic [2:0]           pageIndex,
    // CPU access
    input  wire logic [15:0]          cpuAddr,
    input  wire logic                 cpuValid,
    input  wire logic                 cpuExternal,
    // Decode results
    output logic                      flashSel,
    output logic [3:0]                arraySel,
    output logic [16:0]               flashAddr,
    output logic                      followSel,
    output logic                      followNarrow,
    output logic                      cpuHold,
    output logic [15:0]               busAddr
);
    import mmc_pkg::*;

    logic [7:0]    ctrl_r;
    logic          written_r;
    logic          special;
    logic          normal;
    logic          expWide;
    logic          expanded;
    logic [7:0]    ctrlWrVal;
    logic [7:0]    test0;
    logic [7:0]    test1;
    logic [7:0]    test2;
    logic [7:0]    test3;
    logic [7:0]    rd_nxt;
    logic          testWin;
    logic          flash_enable;
    logic          upperOnly;
    logic          inFollow;
    logic          inFixed;
    logic          inWin;
    logic          flash_nxt;
    logic [3:0]    array_nxt;
    logic [16:0]   faddr_nxt;
    logic [1:0]    stretchNeed;
    mmc_state_type state_r;
    logic [1:0]    stretchLeft_r;
    logic [7:0]    ediv_r;
    logic          startAcc;
    logic          initDone_r;

    assign special  = !opMode[2];
    assign normal   = opMode[2];
    assign expWide  = (opMode[1:0] == 2'h3);
    assign expanded = (opMode[1:0] == 2'h1) || (opMode[1:0] == 2'h3);

    // Normal modes force the test-window bit low
    always_comb
    begin
        ctrlWrVal = regWrData;
        if (normal)
            ctrlWrVal[`MMC_BIT_TEST_WINDOW] = 1'b0; // [RQ2]
    end

    // Reset value depends on mode, caught once after release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            initDone_r <= 1'b0;
        else
            initDone_r <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_r <= `MMC_RST_CTRL_EXP;
        else if (!initDone_r)
            ctrl_r <= expanded ? `MMC_RST_CTRL_EXP : `MMC_RST_CTRL_SC;
        else if (regWr && regAddr == `MMC_OFF_MAP_CTRL && (special || !written_r)) // [RQ1]
            ctrl_r <= ctrlWrVal;
        else if (normal)
            ctrl_r[`MMC_BIT_TEST_WINDOW] <= 1'b0; // [RQ2]
    end

    // Write-once flag, cleared only by reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            written_r <= 1'b0;
        else if (regWr && regAddr == `MMC_OFF_MAP_CTRL && initDone_r)
            written_r <= 1'b1; // [RQ16]
    end

    // Test window exists only in special modes
    assign testWin   = ctrl_r[`MMC_BIT_TEST_WINDOW] && special;
    assign flash_enable     = ctrl_r[`MMC_BIT_FLASH_ENABLE];
    assign upperOnly = ctrl_r[`MMC_BIT_UPPER_HALF] && flash_enable; // [RQ10]

    // Follow space is the upper 1K of the 2K block selected by regBase
    assign inFollow = (cpuAddr[15:11] == regBase) && cpuAddr[10]; // [RQ6]
    assign inFixed  = (cpuAddr[15:14] == 2'h1);
    assign inWin    = testWin ? cpuAddr[15] : (cpuAddr[15:14] == 2'h2); // [RQ3]

    always_comb
    begin
        flash_nxt = 1'b0;
        array_nxt = 4'h0;
        faddr_nxt = 17'h00000;
        if (flash_enable && cpuValid) // [RQ9]
        begin
            if (inWin && testWin)
            begin
                flash_nxt = 1'b1;
                faddr_nxt = {pageIndex[2:1], cpuAddr[14:0]}; // [RQ15]
                if (upperOnly)
                    array_nxt = 4'hF; // [RQ12]
                else
                    array_nxt = 4'h1 << pageIndex[2:1];
            end
            else if (inWin)
            begin
                flash_nxt = 1'b1;
                faddr_nxt = {pageIndex, cpuAddr[13:0]};
                array_nxt = 4'h1 << pageIndex[2:1];
            end
            else if (inFixed && !upperOnly) // [RQ11]
            begin
                flash_nxt = 1'b1;
                faddr_nxt = {3'h6, cpuAddr[13:0]};
                array_nxt = 4'h8;
            end
            // Fixed page 7 outside the test window
            else if (!testWin && cpuAddr[15:14] == 2'h3)
            begin
                flash_nxt = 1'b1;
                faddr_nxt = {3'h7, cpuAddr[13:0]};
                array_nxt = 4'h8;
            end
        end
    end

    // Stretch selection per access type
    always_comb
    begin
        stretchNeed = 2'h0;
        if (expanded && inFollow)
            stretchNeed = ctrl_r[`MMC_BIT_FOLLOW_HI:`MMC_BIT_FOLLOW_LO]; // [RQ7]
        else if (expanded && cpuExternal)
            stretchNeed = ctrl_r[`MMC_BIT_EXT_HI:`MMC_BIT_EXT_LO]; // [RQ8]
    end

    // Accesses start only while the sequencer is idle
    assign startAcc = cpuValid && (state_r == MMC_ST_IDLE);

    // E-clock divider
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ediv_r <= 8'h00;
        else if (startAcc || ediv_r == `MMC_ECLK_DIV - 8'h01)
            ediv_r <= 8'h00;
        else
            ediv_r <= ediv_r + 8'h01;
    end

    // Stretch sequencer holds the bus one E period per count
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r       <= MMC_ST_IDLE;
            stretchLeft_r <= 2'h0;
            cpuHold       <= 1'b0;
            busAddr       <= 16'h0000;
        end
        else
        begin
            case (state_r)
                MMC_ST_IDLE:
                begin
                    if (cpuValid)
                    begin
                        busAddr <= cpuAddr;
                        if (stretchNeed != 2'h0)
                        begin
                            state_r       <= MMC_ST_STRETCH;
                            stretchLeft_r <= stretchNeed;
                            cpuHold       <= 1'b1;
                        end
                    end
                end
                MMC_ST_STRETCH:
                begin
                    if (ediv_r == `MMC_ECLK_DIV - 8'h01) // [RQ17]
                    begin
                        stretchLeft_r <= stretchLeft_r - 2'h1;
                        if (stretchLeft_r == 2'h1)
                        begin
                            state_r <= MMC_ST_DONE;
                            cpuHold <= 1'b0;
                        end
                    end
                end
                MMC_ST_DONE:
                    state_r <= MMC_ST_IDLE;
                default:
                    state_r <= MMC_ST_IDLE;
            endcase
        end
    end

    // Decode outputs registered
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flashSel     <= 1'b0;
            arraySel     <= 4'h0;
            flashAddr    <= 17'h00000;
            followSel    <= 1'b0;
            followNarrow <= 1'b0;
        end
        else
        begin
            flashSel     <= flash_nxt;
            arraySel     <= array_nxt;
            flashAddr    <= faddr_nxt;
            followSel    <= cpuValid && inFollow;
            followNarrow <= cpuValid && inFollow && expWide
                            && ctrl_r[`MMC_BIT_NARROW_FOLLOW]; // [RQ4] [RQ5]
        end
    end

    // Test registers capture decode activity
    mmc_test_reg uTest0 (.clk(clk), .rst_n(rst_n), .setBits(faddr_nxt[7:0]),
        .readClr(regRd && regAddr == `MMC_OFF_MAP_TEST_0), .value(test0));
    mmc_test_reg uTest1 (.clk(clk), .rst_n(rst_n), .setBits(faddr_nxt[15:8]),
        .readClr(regRd && regAddr == `MMC_OFF_MAP_TEST_1), .value(test1));
    mmc_test_reg uTest2 (.clk(clk), .rst_n(rst_n), .setBits({3'h0, faddr_nxt[16], array_nxt}),
        .readClr(regRd && regAddr == `MMC_OFF_MAP_TEST_2), .value(test2));
    mmc_test_reg uTest3 (.clk(clk), .rst_n(rst_n),
        .setBits({4'h0, followSel, flash_nxt, stretchNeed}),
        .readClr(regRd && regAddr == `MMC_OFF_MAP_TEST_3), .value(test3));

    // Read mux; test registers clear as they are read
    always_comb
    begin
        case (regAddr)
            `MMC_OFF_MAP_TEST_0: rd_nxt = test0; // [RQ14]
            `MMC_OFF_MAP_TEST_1: rd_nxt = test1;
            `MMC_OFF_MAP_TEST_2: rd_nxt = test2;
            `MMC_OFF_MAP_TEST_3: rd_nxt = test3;
            `MMC_OFF_MAP_CTRL:   rd_nxt = ctrl_r;
            default:             rd_nxt = 8'h00;
        endcase
    end

    // Read data stands for one cycle only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            regRdData <= 8'h00;
        else if (regRd)
            regRdData <= rd_nxt;
        else
            regRdData <= 8'h00;
    end
endmodule : mmc_map_ctrl

// ===== mmc_map_ctrl_props.sv
/*
 Port assertions for the memory-map control block.
 Bound to mmc_map_ctrl from the bench top file.
*/
`timescale 1ns/1ps
module mmc_map_ctrl_props
(
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  rst_n,
    // Register port
    input wire logic [7:0]            regAddr,
    input wire logic                  regRd,
    input wire logic [7:0]            regRdData,
    // Access and decode
    input wire mmc_pkg::mmc_mode_type opMode,
    input wire logic [4:0]            regBase,
    input wire logic [15:0]           cpuAddr,
    input wire logic                  cpuValid,
    input wire logic                  flashSel,
    input wire logic [3:0]            arraySel,
    input wire logic                  followSel,
    input wire logic                  followNarrow,
    input wire logic                  cpuHold,
    input wire logic [15:0]           busAddr
);
    import mmc_pkg::*;
    logic [4:0] holdLen_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Length of the running stretch
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            holdLen_r <= 5'h00;
        else
            holdLen_r <= cpuHold ? holdLen_r + 5'h01 : 5'h00;
    end
    sequence normCtrlRd;
        regRd && regAddr == 8'hFF && opMode[2];
    endsequence
    AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside read slot");
    AST_WIN_NORM: assert property (normCtrlRd |=> !regRdData[7])
        else $error("test window bit set in normal mode");
    AST_NARROW: assert property (followNarrow |-> opMode[1:0] == 2'h3 && followSel)
        else $error("narrow follow bus outside wide mode");
    AST_FOLLOW: assert property (cpuValid && opMode[0] |=> followSel ==
        ($past(cpuAddr[15:11]) == $past(regBase) && $past(cpuAddr[10])))
        else $error("follow space decode wrong");
    AST_HOLD_ADDR: assert property (cpuHold && $past(cpuHold) |-> $stable(busAddr))
        else $error("address moved during stretch");
    AST_HOLD_LEN: assert property ($fell(cpuHold) |-> holdLen_r inside {5'h04, 5'h08, 5'h0C})
        else $error("stretch not whole E periods");
    AST_NO_STR: assert property (cpuValid && !opMode[0] |=> !cpuHold [*4])
        else $error("stretch in single chip or peripheral mode");
    AST_OVERLAY: assert property (arraySel == 4'hF |-> !opMode[2] && flashSel)
        else $error("overlay outside special mode");
    AST_ONE_ARRAY: assert property (flashSel && arraySel != 4'hF |-> $onehot(arraySel))
        else $error("array select not one hot");
    cover property ($fell(cpuHold) && holdLen_r == 5'h0C);
    cover property (arraySel == 4'hF);
    cover property (followNarrow);
endmodule : mmc_map_ctrl_props

// ===== mmc_ext_bus.sv
/*
 External bus partner: claims the external address range.
 Assumes the bench keeps flash out of 1000-3FFF; follow space enters it once regBase moves to 02.
*/
`timescale 1ns/1ps
module mmc_ext_bus
(
    // Access address
    input  wire logic [15:0] cpuAddr,
    // External claim
    output logic             cpuExternal
);
    // Off-chip devices decode 1000-3FFF
    assign cpuExternal = cpuAddr[15:14] == 2'h0 && cpuAddr[13:12] != 2'h0;
endmodule : mmc_ext_bus

// ===== tb_memory_map_control.sv
/*
 Self-checking bench for mmc_map_ctrl with the external bus partner.
 Assumes mmc_pkg and mmc_regs.svh compiled first.
*/
`include "mmc_regs.svh"
`timescale 1ns/1ps
module tb_memory_map_control;
    import mmc_pkg::*;
    typedef struct packed {logic [15:0] a; logic fl; logic fo;} mmc_row_type;
    logic clk, rst_n, regWr, regRd, cpuValid, cpuExternal, flashSel, followSel;
    logic followNarrow, cpuHold;
    logic [7:0] regAddr, regWrData, regRdData, rdv;
    logic [2:0] pageIndex;
    logic [4:0] regBase;
    logic [15:0] cpuAddr, busAddr;
    logic [3:0] arraySel;
    logic [16:0] flashAddr;
    mmc_mode_type opMode;
    int err_count, n_tests, hl;
    mmc_row_type rows [7] = '{'{16'h4000, 1, 0}, '{16'h8000, 1, 0}, '{16'hC000, 1, 0},
        '{16'h0400, 0, 1}, '{16'h07FF, 0, 1}, '{16'h0800, 0, 0}, '{16'h2000, 0, 0}};
    mmc_map_ctrl mmc_map_ctrl_i (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .opMode(opMode), .regBase(regBase), .pageIndex(pageIndex), .cpuAddr(cpuAddr),
        .cpuValid(cpuValid), .cpuExternal(cpuExternal), .flashSel(flashSel),
        .arraySel(arraySel), .flashAddr(flashAddr), .followSel(followSel),
        .followNarrow(followNarrow), .cpuHold(cpuHold), .busAddr(busAddr));
    mmc_ext_bus mmc_ext_bus_i (.cpuAddr(cpuAddr), .cpuExternal(cpuExternal));
    task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rdv = regRdData;
    endtask : rd
    task acc(input logic [15:0] a);
        @(posedge clk);
        cpuAddr <= a;
        cpuValid <= 1'b1;
        @(posedge clk);
        cpuValid <= 1'b0;
        #1;
    endtask : acc
    task hwait();
        hl = 0;
        while (cpuHold === 1'b1 && hl < 40)
        begin
            hl++;
            @(posedge clk);
            #1;
        end
        if (hl == 40)
        begin
            err_count++;
            print_verdict();
        end
    endtask : hwait
    task rst_pulse(input mmc_mode_type m);
        @(posedge clk);
        rst_n <= 1'b0;
        opMode <= m;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : rst_pulse
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        {rst_n, regWr, regRd, cpuValid, pageIndex, regBase} = '0;
        {regAddr, regWrData, cpuAddr} = '0;
        {err_count, n_tests} = '0;
        opMode = MMC_SPEC_XW;
        rst_pulse(MMC_SPEC_XW);
        rd(8'hFF);
        chk("ctrlExp", `MMC_RST_CTRL_EXP, rdv);
        acc(16'h2000);
        hwait();
        chk("extHold", 17'(3 * `MMC_ECLK_DIV), 17'(hl));
        chk("busAddr", 17'h02000, 17'(busAddr));
        wr(8'hFF, 8'h71);
        acc(16'h0400);
        chk("narrow", 1, followNarrow);
        hwait();
        chk("followHold", 17'(3 * `MMC_ECLK_DIV), 17'(hl));
        $display("test stretch done");
        wr(8'hFF, 8'h01);
        foreach (rows[i])
        begin
            acc(rows[i].a);
            chk("flashSel", rows[i].fl, flashSel);
            chk("followSel", rows[i].fo, followSel);
            hwait();
        end
        wr(8'hFF, 8'h03);
        acc(16'h4000);
        chk("upperOnly", 0, flashSel);
        wr(8'hFF, 8'h02);
        acc(16'h8000);
        chk("flashOff", 0, flashSel);
        pageIndex <= 3'h6;
        wr(8'hFF, 8'h81);
        acc(16'hE000);
        chk("win32", 1, flashSel);
        chk("arraySel", 4'h8, arraySel);
        chk("addrHi", 2'h3, flashAddr[16:15]);
        wr(8'hFF, 8'h83);
        acc(16'h8000);
        chk("overlay", 4'hF, arraySel);
        wr(8'hFF, 8'h81);
        acc(16'h8000);
        chk("overlayOff", 17'h8, 17'(arraySel));
        $display("test decode done");
        @(posedge clk) opMode <= MMC_SPEC_SC;
        wr(8'hFF, 8'h71);
        acc(16'h0400);
        chk("narrowSc", 0, followNarrow);
        hwait();
        chk("scHold", 0, 17'(hl));
        @(posedge clk) regBase <= 5'h02;
        acc(16'h1400);
        chk("followMoved", 17'h1, 17'(followSel));
        acc(16'h0400);
        chk("followOld", 17'h0, 17'(followSel));
        @(posedge clk) regBase <= 5'h00;
        acc(16'hC0A5);
        rd(8'hF8);
        chk("testCapture", 17'hA5, 17'(rdv));
        for (int i = 0; i < 4; i++)
        begin
            rd(8'hF8 + 8'(i));
            wr(8'hF8 + 8'(i), 8'hFF);
            rd(8'hF8 + 8'(i));
            chk("testReg", 0, rdv);
        end
        rd(8'hF0);
        chk("unmapped", 0, rdv);
        $display("test registers done");
        rst_pulse(MMC_NORM_SC);
        rd(8'hFF);
        chk("ctrlSc", `MMC_RST_CTRL_SC, rdv);
        wr(8'hFF, 8'hF1);
        rd(8'hFF);
        chk("winForced", 8'h71, rdv);
        wr(8'hFF, 8'h0D);
        rd(8'hFF);
        chk("writeOnce", 8'h71, rdv);
        $display("test write once done");
        print_verdict();
    end
endmodule : tb_memory_map_control
bind mmc_map_ctrl mmc_map_ctrl_props mmc_map_ctrl_props_i (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData), .opMode(opMode),
    .regBase(regBase), .cpuAddr(cpuAddr), .cpuValid(cpuValid), .flashSel(flashSel),
    .arraySel(arraySel), .followSel(followSel), .followNarrow(followNarrow),
    .cpuHold(cpuHold), .busAddr(busAddr));
